/* File: hdl/wwd_defs.vh */
// Constants for the windowed watchdog timer: offsets, fields, keys, reset values.
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH
// Register byte offsets.
`define WWD_OFF_CTRL      12'h000
`define WWD_OFF_CLEAR     12'h004
`define WWD_OFF_STATUS    12'h008
`define WWD_OFF_VERSION   12'h3FC
// Key field and key values.
`define WWD_KEY_MSB       31
`define WWD_KEY_LSB       24
`define WWD_KEY_FIRST     8'h55
`define WWD_KEY_SECOND    8'hAA
// Control word field positions.
`define WWD_F_EN          0
`define WWD_F_DIS_AFTER_RST 1
`define WWD_F_MODE        2
`define WWD_F_LOCK        3
`define WWD_F_CALDONE     7
`define WWD_F_PSEL_LSB    8
`define WWD_F_PSEL_MSB    12
`define WWD_F_CLK_EN      16
`define WWD_F_CLK_SRC     17
`define WWD_F_TBAN_LSB    18
`define WWD_F_TBAN_MSB    22
// Control word as read after a cold reset once calibration is done, and reset value of the status word.
`define WWD_CTRL_RESET    32'h00010080
`define WWD_STATUS_RESET  2'h3
// Timeout select given by the auto-enable fuse (period above 100 ms).
`define WWD_AUTO_PSEL     5'h11
// Last count of counter clock ticks before an enable change lands (four ticks in all).
`define WWD_SYNC_CYCLES   3'h3
// AXI response codes.
`define WWD_RESP_OKAY     2'h0
`define WWD_RESP_SLVERR   2'h2
`endif

/* File: hdl/wwd_timer.v */
// Windowed watchdog timer with keyed control, keyed clear and an AXI4-Lite slave.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "wwd_defs.vh"
// Functional notes
// - Control write needs keys 0x55 then 0xAA.
// - Non-watchdog reset enables clock, selects RC.
// - Basic mode timeout is 2^(psel+1).
// - Enable read-back follows synchronised state.
// - Clear, control write, timeout zero counter.
// - Clear-done drops on clear; ignores clears.
// - Clear needs keys 0x55 then 0xAA.
// - Timeout clears counter, requests chip reset.
// - Disable-after-reset drops only enable bit.
// - Fuse and no calibration block disable-after-reset.
// - Window timeout is ban plus timeout.
// - Clear inside ban period causes reset.
// - Clear after ban restarts from zero.
// - Control change clears counter without reset.
// - Mode changes only while disabled.
// - Disable by enable zero, others unchanged.
// - Fuse enables basic mode, RC, long period.
// - Calibration redone unless done at watchdog reset.
// - Lock ignores control writes until reset.
// - Enabled watchdog keeps its clock in sleep.
// - Counter frozen in debug unless both run.
module wwd_timer #(
    parameter CNT_W = 32,             // Width of the watchdog counter.
    parameter [31:0] VERSION_ID = 32'h00000001 // Arbitrary version value.
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        watchdog_reset_cause,  // Last reset came from the watchdog.
    input  wire        auto_enable_fuse,      // Fuse that enables the watchdog at reset.
    input  wire        calibration_complete,  // Pulse when flash calibration finishes.
    input  wire        internal_rc_osc,       // RC oscillator tick (asynchronous).
    input  wire        slow_crystal_osc,      // Crystal oscillator tick (asynchronous).
    input  wire        debug_halt,            // CPU is halted in debug.
    input  wire        run_in_debug,          // Global run-in-debug setting.
    input  wire        periph_debug_run,      // Per-peripheral debug-run setting.
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         watchdog_reset_req,    // One-cycle request to the reset controller.
    output wire        keep_clock_in_sleep    // Sleep controller must keep counter clock.
);

// =====================================================================
// Counter clock tick synchronisers
// =====================================================================
reg  [2:0] rc_sync_q;     // Stage 0 and 1 synchronise, stage 2 detects edges.
reg  [2:0] xt_sync_q;     // Same for the crystal source.

// Two flip-flops before any logic, then an edge detector on the settled copy.
always @(posedge aclk) begin
    if (!aresetn) begin
        rc_sync_q <= 3'h0;
        xt_sync_q <= 3'h0;
    end else begin
        // Shift in the raw oscillator levels.
        rc_sync_q <= {rc_sync_q[1:0], internal_rc_osc};
        xt_sync_q <= {xt_sync_q[1:0], slow_crystal_osc};
    end
end

// =====================================================================
// Control word and status
// =====================================================================
reg              en_q;         // Enable as written by software.
reg              en_eff_q;     // Enable as seen in the counter domain.
reg              disable_after_reset_q;      // Disable after reset.
reg              mode_q;       // Zero basic, one window.
reg              lock_q;       // Control word locked.
reg              caldone_q;    // Flash calibration done.
reg  [4:0]       psel_q;       // Timeout select.
reg              counter_clock_enable_q;     // Counter clock enable as written.
reg              counter_clock_enable_eff_q; // Counter clock enable as synchronised.
reg              counter_clock_source_q;     // Zero selects RC, one crystal.
reg  [4:0]       tban_q;       // Ban select.
reg              ctrl_armed_q; // First control key seen.
reg  [31:0]      ctrl_first_q; // First control write, checked against second.
reg              clr_armed_q;  // First clear key seen.
reg              cleared_q;    // Clear-done status.
reg              clr_pend_q;   // Clear waiting for the counter domain.
reg  [2:0]       sync_cnt_q;   // Ticks until a pending change lands.
reg  [CNT_W-1:0] count_q;      // The watchdog counter.
reg              restart_q;    // Counter must restart after a control change.

// Selected counter clock tick, gated by the synchronised clock enable.
// Edge detect: stage 1 is already high while stage 2 is still low.
wire rc_edge = rc_sync_q[1] & ~rc_sync_q[2];
wire xt_edge = xt_sync_q[1] & ~xt_sync_q[2];
wire tick    = counter_clock_enable_eff_q && (counter_clock_source_q ? xt_edge : rc_edge);
wire frozen = debug_halt && !(run_in_debug && periph_debug_run);
assign keep_clock_in_sleep = en_eff_q;

// Two raised to (sel plus one) in CNT_W+1 bits; a larger shift gives zero.
function [CNT_W:0] wwd_pow2;
    input [4:0] sel;
    begin
        wwd_pow2 = {{CNT_W{1'b0}}, 1'b1} << ({1'b0, sel} + 6'h01);
    end
endfunction

wire [CNT_W:0] ban_len  = mode_q ? wwd_pow2(tban_q) : {(CNT_W+1){1'b0}};
wire [CNT_W:0] total    = ban_len + wwd_pow2(psel_q);
wire           in_ban   = ({1'b0, count_q} < ban_len);
wire [1:0]     status   = {cleared_q, ~in_ban};

// =====================================================================
// AXI4-Lite write channel
// =====================================================================
reg        aw_hold_q;            // Write address accepted.
reg        w_hold_q;             // Write data accepted.
reg [11:0] aw_addr_q;            // Held write address.
reg [31:0] w_data_q;             // Held write data.

// Each half is taken once and refused while the response is pending.
assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
wire   wr_go   = aw_hold_q && w_hold_q;
// Key field decode of the held write data.
wire   key1    = w_data_q[`WWD_KEY_MSB:`WWD_KEY_LSB] == `WWD_KEY_FIRST;
wire   key2    = w_data_q[`WWD_KEY_MSB:`WWD_KEY_LSB] == `WWD_KEY_SECOND;
wire   ctrl_wr = wr_go && (aw_addr_q[11:2] == `WWD_OFF_CTRL >> 2);
wire   clr_wr  = wr_go && (aw_addr_q[11:2] == `WWD_OFF_CLEAR >> 2);
wire   ctrl_ok = ctrl_wr && key2 && ctrl_armed_q && !lock_q &&
                 (w_data_q[23:0] == ctrl_first_q[23:0]);
wire   clr_ok  = clr_wr && key2 && clr_armed_q && w_data_q[0] && cleared_q;
// Only the three working registers accept writes.
wire   mapped  = (aw_addr_q[11:2] <= 10'h002);

// Accepts address and data in either order and answers once both are in.
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        aw_addr_q    <= 12'h000;
        w_data_q     <= 32'h00000000;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `WWD_RESP_OKAY;
    end else begin
        // Address taken; it waits here until the data has arrived too.
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        // Data taken; it waits here until the address has arrived too.
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
        end
        // Both halves held: the write acts now and the response rises.
        if (wr_go) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
        // The response stands until the master takes it.
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// =====================================================================
// Control word, key tracking and counter
// =====================================================================
// A watchdog event in this cycle (timeout or clear in ban).
reg wd_event;

always @* begin
    // No event unless one of the two causes below is present.
    wd_event = 1'b0;
    if (en_eff_q && tick && !frozen && !restart_q &&
        ({1'b0, count_q} + {{CNT_W{1'b0}}, 1'b1} >= total)) begin
        wd_event = 1'b1;
    end
    if (clr_ok && en_eff_q && mode_q && in_ban) begin
        wd_event = 1'b1;
    end
end

// Holds the control word; reset values depend on reset cause and fuse.
always @(posedge aclk) begin
    if (!aresetn) begin
        lock_q       <= 1'b0;
        ctrl_armed_q <= 1'b0;
        ctrl_first_q <= 32'h00000000;
        clr_armed_q  <= 1'b0;
        restart_q    <= 1'b1;
        // Cold reset: settings return to their defaults.
        if (!watchdog_reset_cause) begin
            counter_clock_enable_q <= 1'b1;
            counter_clock_source_q <= 1'b0;
            // Only the fuse may impose anything beyond the defaults.
            disable_after_reset_q  <= 1'b0;
            tban_q    <= 5'h00;
            caldone_q <= 1'b0;
            en_q      <= auto_enable_fuse;
            mode_q    <= 1'b0;
            psel_q    <= auto_enable_fuse ? `WWD_AUTO_PSEL : 5'h00;
        end else begin
            // drop only enable
            // The rest of the word survives so software can see how it was set, except the lock bit, which clears, and mode, which a fused uncalibrated part clears.
            if (disable_after_reset_q) begin
                en_q <= 1'b0;
            end
            if (!caldone_q && auto_enable_fuse) begin
                en_q   <= 1'b1;
                mode_q <= 1'b0;
            end
        end
    end else begin
        // The restart request lasts one cycle.
        restart_q <= 1'b0;
        if (calibration_complete) begin
            caldone_q <= 1'b1;
        end
        // Any control write arms or disarms the key sequence.
        if (ctrl_wr) begin
            ctrl_armed_q <= key1 && !lock_q;
            ctrl_first_q <= w_data_q;
        end
        // Any clear write arms or disarms the clear sequence.
        if (clr_wr) begin
            clr_armed_q <= key1 && w_data_q[0];
        end
        // A complete keyed pair updates the control word.
        if (ctrl_ok) begin
            en_q    <= w_data_q[`WWD_F_EN];
            // fuse blocks disable
            // A fused watchdog may not set disable-after-reset before calibration ends.
            if (!(auto_enable_fuse && !caldone_q && w_data_q[`WWD_F_DIS_AFTER_RST])) begin
                disable_after_reset_q <= w_data_q[`WWD_F_DIS_AFTER_RST];
            end
            if (!en_eff_q && !en_q) begin
                mode_q <= w_data_q[`WWD_F_MODE];
            end
            lock_q  <= w_data_q[`WWD_F_LOCK];
            psel_q  <= w_data_q[`WWD_F_PSEL_MSB:`WWD_F_PSEL_LSB];
            // Clock enable and source; software stops the clock before a swap.
            counter_clock_enable_q <= w_data_q[`WWD_F_CLK_EN];
            counter_clock_source_q <= w_data_q[`WWD_F_CLK_SRC];
            tban_q  <= w_data_q[`WWD_F_TBAN_MSB:`WWD_F_TBAN_LSB];
            restart_q <= 1'b1;
        end
    end
end

// Synchronises enable and clear into counter time; clock enable lags one system cycle.
always @(posedge aclk) begin
    if (!aresetn) begin
        en_eff_q    <= 1'b0;
        counter_clock_enable_eff_q <= 1'b1;
        cleared_q   <= 1'b1;
        clr_pend_q  <= 1'b0;
        sync_cnt_q  <= 3'h0;
        count_q     <= {CNT_W{1'b0}};
        watchdog_reset_req <= 1'b0;
    end else begin
        watchdog_reset_req <= 1'b0;
        // Clock enable lands on the next system cycle since the source may stop.
        counter_clock_enable_eff_q <= counter_clock_enable_q;
        // enable after synchronisation
        // A stopped counter clock freezes the hand-over, so a disable never lands.
        if (en_q != en_eff_q && counter_clock_enable_eff_q) begin
            if (tick) begin
                if (sync_cnt_q == `WWD_SYNC_CYCLES) begin
                    en_eff_q   <= en_q;
                    sync_cnt_q <= 3'h0;
                end else begin
                    sync_cnt_q <= sync_cnt_q + 3'h1;
                end
            end
        end
        if (clr_ok && !(mode_q && in_ban && en_eff_q)) begin
            cleared_q  <= 1'b0;
            clr_pend_q <= 1'b1;
        end
        // A control change restarts the count and outranks everything else.
        if (restart_q) begin
            count_q <= {CNT_W{1'b0}};
        end else if (wd_event) begin
            count_q <= {CNT_W{1'b0}};
            watchdog_reset_req <= 1'b1;
        end else if (clr_pend_q && tick) begin
            count_q    <= {CNT_W{1'b0}};
            clr_pend_q <= 1'b0;
            cleared_q  <= 1'b1;
        end else if (en_eff_q && tick && !frozen) begin
            // Normal counting on each selected tick.
            count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// =====================================================================
// AXI4-Lite read channel
// =====================================================================
// One read at a time: a new address waits until the data is taken.
assign s_axi_arready = !s_axi_rvalid;

// Returns one word per read; key field reads zero.
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= `WWD_RESP_OKAY;
    // Address taken: data and response are registered for the next cycle.
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `WWD_RESP_OKAY;
        case (s_axi_araddr[11:2])
            // Control word with enable and clock enable as synchronised.
            `WWD_OFF_CTRL >> 2:
                s_axi_rdata <= {9'h000, tban_q, counter_clock_source_q,
                                counter_clock_enable_eff_q, 3'h0, psel_q,
                                caldone_q, 3'h0, lock_q, mode_q,
                                disable_after_reset_q, en_eff_q};
            // The clear register is write-only and reads zero.
            `WWD_OFF_CLEAR >> 2:   s_axi_rdata <= 32'h00000000;
            `WWD_OFF_STATUS >> 2:  s_axi_rdata <= {30'h00000000, status};
            `WWD_OFF_VERSION >> 2: s_axi_rdata <= VERSION_ID;
            // Unmapped words answer with an error.
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `WWD_RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // wwd_timer

/* File: verif/testbench.sv */
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
`include "wwd_defs.vh"
module testbench;
    logic        aclk = 0, aresetn = 0, cause = 0, fuse = 0, rc = 0, halt = 0, rid = 0;
    logic        xt = 0, cal = 0, src = 0;  // Crystal tick, calibration pulse, source in use.
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, req, keep;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          err_count = 0, n_compared = 0, req_seen = 0, base, n;
    // ==========================================================
    // Clock, request counter and the design.
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (req) req_seen++;
    wwd_timer #(.VERSION_ID(32'h00000001)) wwd_timer_i (
        .aclk(aclk), .aresetn(aresetn), .watchdog_reset_cause(cause),
        .auto_enable_fuse(fuse), .calibration_complete(cal), .internal_rc_osc(rc),
        .slow_crystal_osc(xt), .debug_halt(halt), .run_in_debug(rid),
        .periph_debug_run(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watchdog_reset_req(req), .keep_clock_in_sleep(keep));
    // ==========================================================
    // Compare, bus and stimulus tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One AXI write; ready is judged just before the edge that moves the item.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ag, wg, bg;
        int   t;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        t = 0;
        bg = 0;
        while (!bg && t < 40) begin
            @(negedge aclk);
            ag = awvalid && awready;
            wg = wvalid && wready;
            bg = bvalid;
            @(posedge aclk);
            if (ag) awvalid <= 0;
            if (wg) wvalid <= 0;
            t++;
        end
        bready <= 0;
        if (!bg) chk(0, 1);
        @(posedge aclk);
    endtask
    // One AXI read returning data and response.
    task automatic rd(input logic [11:0] a);
        logic ag, rg;
        int   t;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        t = 0;
        rg = 0;
        while (!rg && t < 40) begin
            @(negedge aclk);
            ag = arvalid && arready;
            rg = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ag) arvalid <= 0;
            t++;
        end
        rready <= 0;
        if (!rg) chk(0, 1);
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(d & m, e);
    endtask
    // Keyed pair of writes with identical low bits.
    task automatic kw(input logic [11:0] a, input logic [23:0] v);
        wr(a, {`WWD_KEY_FIRST, v});
        wr(a, {`WWD_KEY_SECOND, v});
    endtask
    // Counter clock ticks on the source in use, each four bus clocks long.
    task automatic tick(input int k);
        repeat (k) begin
            rc <= !src;
            xt <= src;
            repeat (2) @(posedge aclk);
            rc <= 0;
            xt <= 0;
            repeat (2) @(posedge aclk);
        end
    endtask
    task automatic do_reset(input logic c, input logic f);
        cause <= c;
        fuse <= f;
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        if (!c) src = 0;
        @(posedge aclk);
        // calibration ends after a cold reset; the fuse case leaves it pending.
        cal <= !c && !f;
        @(posedge aclk);
        cal <= 0;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        rchk(`WWD_OFF_CTRL, 32'hFFFFFFFF, 32'h00010080);
        rchk(`WWD_OFF_STATUS, 32'hFFFFFFFF, 32'h00000003);
        rchk(`WWD_OFF_VERSION, 32'hFFFFFFFF, 32'h00000001);
        rd(12'h010);
        chk(r, `WWD_RESP_SLVERR);
    endtask
    task automatic t_keys;
        wr(`WWD_OFF_CTRL, 32'h55010481);
        wr(`WWD_OFF_CTRL, 32'h55010481);
        rchk(`WWD_OFF_CTRL, 32'hFFFFFFFF, 32'h00010080);
        kw(`WWD_OFF_CTRL, 24'h010481);
        rchk(`WWD_OFF_CTRL, 32'hFFFFFFFF, 32'h00010480);
        tick(6);
        rchk(`WWD_OFF_CTRL, 32'hFFFFFFFF, 32'h00010481);
    endtask
    // Halted counter must not expire; free counter expires after 16 ticks.
    task automatic t_timeout;
        kw(`WWD_OFF_CTRL, 24'h010381);
        halt <= 1;
        base = req_seen;
        tick(24);
        chk(req_seen, base);
        halt <= 0;
        n = 0;
        while (req_seen == base && n < 40) begin
            tick(1);
            n++;
        end
        chk(n >= 16 && n <= 20, 1);
    endtask
    task automatic t_clear;
        base = req_seen;
        tick(10);
        wr(`WWD_OFF_CLEAR, 32'hAA000001);
        rchk(`WWD_OFF_STATUS, 32'h2, 32'h2);
        kw(`WWD_OFF_CLEAR, 24'h000001);
        rchk(`WWD_OFF_STATUS, 32'h2, 32'h0);
        tick(10);
        rchk(`WWD_OFF_STATUS, 32'h2, 32'h2);
        chk(req_seen, base);
    endtask
    task automatic t_window;
        kw(`WWD_OFF_CTRL, 24'h010385);
        rchk(`WWD_OFF_CTRL, 32'h4, 32'h0);
        kw(`WWD_OFF_CTRL, 24'h010380);
        tick(6);
        rchk(`WWD_OFF_CTRL, 32'h1, 32'h0);
        kw(`WWD_OFF_CTRL, 24'h000380);
        rchk(`WWD_OFF_CTRL, 32'h10000, 32'h0);
        kw(`WWD_OFF_CTRL, 24'h020380);
        kw(`WWD_OFF_CTRL, 24'h030380);
        rchk(`WWD_OFF_CTRL, 32'h30000, 32'h30000);
        src = 1;
        kw(`WWD_OFF_CTRL, 24'h0B0387);
        tick(6);
        rchk(`WWD_OFF_STATUS, 32'h1, 32'h0);
        base = req_seen;
        kw(`WWD_OFF_CLEAR, 24'h000001);
        tick(1);
        chk(req_seen, base + 1);
        tick(10);
        rchk(`WWD_OFF_STATUS, 32'h1, 32'h1);
        kw(`WWD_OFF_CLEAR, 24'h000001);
        tick(2);
        rchk(`WWD_OFF_STATUS, 32'h1, 32'h0);
        chk(req_seen, base + 1);
    endtask
    task automatic t_lock;
        kw(`WWD_OFF_CTRL, 24'h0B038F);
        kw(`WWD_OFF_CTRL, 24'h0B0487);
        rchk(`WWD_OFF_CTRL, 32'h00001F00, 32'h00000300);
        do_reset(1, 0);
        rchk(`WWD_OFF_CTRL, 32'h007F1F8F, 32'h000B0386);
        do_reset(0, 1);
        rchk(`WWD_OFF_CTRL, 32'h00071F04, 32'h00011100);
        tick(6);
        rchk(`WWD_OFF_CTRL, 32'h1, 32'h1);
        kw(`WWD_OFF_CTRL, 24'h011103);
        rchk(`WWD_OFF_CTRL, 32'h2, 32'h0);
    endtask
    // ==========================================================
    // Verdict, main sequence and hang guard.
    task automatic print_verdict;
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        do_reset(0, 0);
        t_reset();
        t_keys();
        t_timeout();
        t_clear();
        t_window();
        t_lock();
        print_verdict();
    end
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
endmodule  // testbench

/* File: verif/wwd_timer_asserts.sv */
// Port-level assertions for the windowed watchdog timer.
`timescale 1ns/1ps
module wwd_timer_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire        debug_halt,
    input wire        run_in_debug,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        watchdog_reset_req,
    input wire        keep_clock_in_sleep
);
    // ==========================================================
    // Bus channel and reset request checks, all on one clock.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken with response due");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken with data due");
    property p_w_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_w_answer: assert property (p_w_answer) else $error("write response late");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h010 |=> s_axi_rresp == 2'h2;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_req_pulse;
        watchdog_reset_req |=> !watchdog_reset_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
    property p_req_enabled;
        watchdog_reset_req |-> $past(keep_clock_in_sleep);
    endproperty
    a_req_enabled: assert property (p_req_enabled) else $error("request while disabled");
    property p_freeze;
        (debug_halt && !run_in_debug && !s_axi_wvalid) [*4] |-> !watchdog_reset_req;
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter ran during halt");
    property p_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !watchdog_reset_req;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
endmodule  // wwd_timer_asserts
bind wwd_timer wwd_timer_asserts wwd_timer_asserts_i (
    .aclk(aclk), .aresetn(aresetn), .debug_halt(debug_halt), .run_in_debug(run_in_debug),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .watchdog_reset_req(watchdog_reset_req), .keep_clock_in_sleep(keep_clock_in_sleep)
);
